// *** hw/pin_mux_top.sv ***
// Top of the multipurpose pin block: registers, selection and pin drivers.
// Assumes a plain register port and synchronous pin inputs on one 40 MHz clock.
`timescale 1ns/100ps
`include "pin_mux_regs.svh"

// Function
// - Pin 0 resets as an output.
// - Pins 1 to 3 reset as inputs; one means output.
// - Upper nibble holds pin data; reads give pin level, writes store drive value.
// - With register data function, written data bit drives the pin.
// - Four-bit select per pin across two select registers.
// - Code 0000 drives the serial port data output.
// - Codes 0001 and 0010 drive FIFO full and read done.
// - Code 0011 drives filter ready, active low.
// - Codes 0100 and 0101 drive high and low detect.
// - Code 0110 drives the status alert, active low.
// - Code 1000 makes an active-low filter sync input.
// - Code 1001 makes an external FIFO trigger input.
// - Both select registers reset to zero.
// - High detect passes onward only while its route enable is set.
module pin_mux_top #(
    parameter int PINS = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe_n,
    input wire logic serialDataOut,
    input wire logic fifoFull,
    input wire logic fifoReadDone,
    input wire logic filterReadyN,
    input wire logic highDetect,
    input wire logic lowDetect,
    input wire logic alertN,
    output logic highDetectRouted,
    output logic filterSyncN,
    output logic fifoTrigger
);
    if (PINS != 4) begin : g_bad_pins
        $error("pin_mux_top supports exactly four pins");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] dirData_reg;
    logic [7:0] selLow_reg;
    logic [7:0] selHigh_reg;
    logic [7:0] routeCtrl_reg;
    logic [7:0] readData_next;
    logic [PINS-1:0] pin0_drive_enable;
    logic high_detect_route_enable;

    assign pin0_drive_enable = dirData_reg[PINS-1:0];
    assign high_detect_route_enable = routeCtrl_reg[`HIGH_DETECT_ROUTE_ENABLE_BIT];

    always_ff @(posedge clock) begin
        if (rst) begin
            dirData_reg <= `RST_DIR_DATA;
        end else if (regWrite && regAddr == `ADDR_DIR_DATA) begin
            dirData_reg <= regWriteData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            selLow_reg <= `RST_SEL;
            selHigh_reg <= `RST_SEL;
        end else if (regWrite) begin
            if (regAddr == `ADDR_SEL_LOW) begin
                selLow_reg <= regWriteData;
            end
            if (regAddr == `ADDR_SEL_HIGH) begin
                selHigh_reg <= regWriteData;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            routeCtrl_reg <= `RST_ROUTE_CTRL;
        end else if (regWrite && regAddr == `ADDR_ROUTE_CTRL) begin
            routeCtrl_reg <= regWriteData;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb begin
        case (regAddr)
            `ADDR_DIR_DATA: readData_next = {pinIn, dirData_reg[PINS-1:0]};
            `ADDR_SEL_LOW: readData_next = selLow_reg;
            `ADDR_SEL_HIGH: readData_next = selHigh_reg;
            `ADDR_ROUTE_CTRL: readData_next = routeCtrl_reg;
            default: readData_next = `READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            regReadData <= `READ_UNMAPPED;
        end else if (regRead) begin
            regReadData <= readData_next;
        end else begin
            regReadData <= `READ_UNMAPPED;
        end
    end

    // ----------------------------------------------------------------
    // Source routing and selection
    // ----------------------------------------------------------------
    // Masking here keeps the routed high detect output and the pin selection in step with one gate.
    logic highMasked;
    assign highMasked = highDetect & high_detect_route_enable;

    pin_mux_if #(.PINS(PINS)) muxBus ();
    assign muxBus.driveEnable = pin0_drive_enable;
    assign muxBus.dataValue = dirData_reg[`DATA_LSB +: PINS];
    assign muxBus.functionSel = {selHigh_reg, selLow_reg};
    assign muxBus.sourceBits = {1'b0, alertN, lowDetect, highMasked, filterReadyN,
        fifoReadDone, fifoFull, serialDataOut};

    pin_mux_select #(.PINS(PINS)) selectUnit (
        .bus(muxBus.mux)
    );

    pin_input_sense #(.PINS(PINS)) senseUnit (
        .clock(clock),
        .rst(rst),
        .functionSel({selHigh_reg, selLow_reg}),
        .driveEnable(pin0_drive_enable),
        .pinLevel(pinIn),
        .filterSyncN(filterSyncN),
        .fifoTrigger(fifoTrigger)
    );

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // One cycle of latency on every pin keeps outputs glitch free.
    always_ff @(posedge clock) begin
        if (rst) begin
            pinOut <= '0;
            pinOe_n <= {{(PINS-1){1'b1}}, 1'b0};
            highDetectRouted <= 1'b0;
        end else begin
            pinOut <= muxBus.pinOut;
            pinOe_n <= ~muxBus.pinDrive;
            highDetectRouted <= highMasked;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_RESET_DIR: assert property (@(posedge clock)
        $past(rst) && !rst |-> dirData_reg == `RST_DIR_DATA && pinOe_n[0] == 1'b0)
        else $error("pin 0 not output after reset");
    AST_RESET_IN: assert property (@(posedge clock)
        $past(rst) && !rst |-> pinOe_n[3:1] == 3'h7)
        else $error("pins 1 to 3 not inputs after reset");
    AST_SEL_RESET: assert property (@(posedge clock)
        $past(rst) && !rst |-> selLow_reg == `RST_SEL && selHigh_reg == `RST_SEL)
        else $error("select registers not cleared");
    AST_READBACK: assert property (@(posedge clock) disable iff (rst)
        regRead && regAddr == `ADDR_DIR_DATA |=> regReadData[7:4] == $past(pinIn))
        else $error("data readback not pin level");
    AST_DATA_DRIVE: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[3:0] == 4'h7 && dirData_reg[0] |=> pinOut[0] == $past(dirData_reg[4]))
        else $error("pin 0 data not driven");
    AST_SERIAL: assert property (@(posedge clock) disable iff (rst)
        selHigh_reg[7:4] == 4'h0 |=> pinOut[3] == $past(serialDataOut))
        else $error("pin 3 serial output wrong");
    AST_ALERT: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[7:4] == 4'h6 |=> pinOut[1] == $past(alertN))
        else $error("pin 1 alert wrong");
    AST_INPUT_NODRIVE: assert property (@(posedge clock) disable iff (rst)
        selHigh_reg[3:0] == 4'h8 |=> pinOe_n[2])
        else $error("sync input pin driven");
    AST_HIGH_MASK: assert property (@(posedge clock) disable iff (rst)
        !high_detect_route_enable |=> !highDetectRouted)
        else $error("high detect leaked while masked");
    AST_TRIGGER: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[3:0] == 4'h9 && !dirData_reg[0] && pinIn[0] |=> fifoTrigger)
        else $error("trigger input missed");

    // ----------------------------------------------------------------
    // Further checks per pin and per source
    // ----------------------------------------------------------------
    // full flag on pin 0
    AST_FULL_P0: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[3:0] == pin_mux_pkg::FN_FIFO_FULL |=> pinOut[0] == $past(fifoFull))
        else $error("pin 0 full flag wrong");
    AST_DONE_P2: assert property (@(posedge clock) disable iff (rst)
        selHigh_reg[3:0] == pin_mux_pkg::FN_FIFO_READ_DONE |=> pinOut[2] == $past(fifoReadDone))
        else $error("pin 2 read done wrong");
    AST_READY_P1: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[7:4] == pin_mux_pkg::FN_FILTER_READY_N |=> pinOut[1] == $past(filterReadyN))
        else $error("pin 1 filter ready wrong");
    AST_HIGH_P3: assert property (@(posedge clock) disable iff (rst)
        selHigh_reg[7:4] == pin_mux_pkg::FN_HIGH_DETECT |=> pinOut[3] == $past(highMasked))
        else $error("pin 3 high detect wrong");
    AST_LOW_P0: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[3:0] == pin_mux_pkg::FN_LOW_DETECT |=> pinOut[0] == $past(lowDetect))
        else $error("pin 0 low detect wrong");
    AST_DATA_P1: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[7:4] == pin_mux_pkg::FN_REG_DATA |=> pinOut[1] == $past(dirData_reg[5]))
        else $error("pin 1 data wrong");
    AST_DATA_P2: assert property (@(posedge clock) disable iff (rst)
        selHigh_reg[3:0] == pin_mux_pkg::FN_REG_DATA |=> pinOut[2] == $past(dirData_reg[6]))
        else $error("pin 2 data wrong");
    AST_DATA_P3: assert property (@(posedge clock) disable iff (rst)
        selHigh_reg[7:4] == pin_mux_pkg::FN_REG_DATA |=> pinOut[3] == $past(dirData_reg[7]))
        else $error("pin 3 data wrong");
    AST_DIR_P3: assert property (@(posedge clock) disable iff (rst)
        selHigh_reg[7:4] == pin_mux_pkg::FN_REG_DATA |=> pinOe_n[3] == !$past(dirData_reg[3]))
        else $error("pin 3 direction wrong");
    AST_TRIG_NODRIVE: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[3:0] == pin_mux_pkg::FN_FIFO_TRIGGER_IN |=> pinOe_n[0])
        else $error("trigger input pin driven");
    AST_TRIG_IDLE: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[3:0] != pin_mux_pkg::FN_FIFO_TRIGGER_IN &&
        selLow_reg[7:4] != pin_mux_pkg::FN_FIFO_TRIGGER_IN &&
        selHigh_reg[3:0] != pin_mux_pkg::FN_FIFO_TRIGGER_IN &&
        selHigh_reg[7:4] != pin_mux_pkg::FN_FIFO_TRIGGER_IN |=> !fifoTrigger)
        else $error("trigger without trigger input");
    AST_SYNC_LOW: assert property (@(posedge clock) disable iff (rst)
        selLow_reg[7:4] == pin_mux_pkg::FN_FILTER_SYNC_IN && !dirData_reg[1] && !pinIn[1]
        |=> !filterSyncN)
        else $error("sync input missed");
    AST_HIGH_PASS: assert property (@(posedge clock) disable iff (rst)
        high_detect_route_enable |=> highDetectRouted == $past(highDetect))
        else $error("high detect not routed");
    AST_READ_IDLE: assert property (@(posedge clock) disable iff (rst)
        !regRead |=> regReadData == `READ_UNMAPPED)
        else $error("read data outside read cycle");
    AST_READ_SEL: assert property (@(posedge clock) disable iff (rst)
        regRead && regAddr == `ADDR_SEL_LOW |=> regReadData == $past(selLow_reg))
        else $error("select readback wrong");
    AST_WRITE_DATA: assert property (@(posedge clock) disable iff (rst)
        regWrite && regAddr == `ADDR_DIR_DATA |=> dirData_reg == $past(regWriteData))
        else $error("pin data write lost");
    AST_WRITE_SEL: assert property (@(posedge clock) disable iff (rst)
        regWrite && regAddr == `ADDR_SEL_HIGH |=> selHigh_reg == $past(regWriteData))
        else $error("select write lost");
endmodule

// *** hw/pin_mux_regs.svh ***
// Register offsets, reset values and field positions of the multipurpose pin block.
// Assumes inclusion by bare name from hw/ files; definitions only.
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_DIR_DATA 8'h19
`define ADDR_SEL_LOW 8'h1A
`define ADDR_SEL_HIGH 8'h1B
`define ADDR_ROUTE_CTRL 8'h1C

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define RST_DIR_DATA 8'h01
`define RST_SEL 8'h00
`define RST_ROUTE_CTRL 8'h00
`define DATA_LSB 4
`define HIGH_DETECT_ROUTE_ENABLE_BIT 6
`define SEL_WIDTH 4
`define READ_UNMAPPED 8'h00

`endif

// *** hw/pin_mux_pkg.sv ***
// Types shared by the multipurpose pin block.
// Assumes the register header supplies offsets and reset values.
package pin_mux_pkg;

    // ----------------------------------------------------------------
    // Function select codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FN_SERIAL_OUT = 4'b0000,
        FN_FIFO_FULL = 4'b0001,
        FN_FIFO_READ_DONE = 4'b0010,
        FN_FILTER_READY_N = 4'b0011,
        FN_HIGH_DETECT = 4'b0100,
        FN_LOW_DETECT = 4'b0101,
        FN_ALERT_N = 4'b0110,
        FN_REG_DATA = 4'b0111,
        FN_FILTER_SYNC_IN = 4'b1000,
        FN_FIFO_TRIGGER_IN = 4'b1001,
        FN_FORBIDDEN = 4'b1010
    } pin_function_type;

endpackage

// *** hw/pin_mux_if.sv ***
// Interface carrying per-pin configuration and sources between the pin modules.
// Assumes one clock domain and a pin count set by the parent.
`timescale 1ns/100ps
interface pin_mux_if #(
    parameter int PINS = 4
);
    logic [PINS-1:0] driveEnable;
    logic [PINS-1:0] dataValue;
    logic [PINS*4-1:0] functionSel;
    logic [7:0] sourceBits;
    logic [PINS-1:0] pinOut;
    logic [PINS-1:0] pinDrive;

    modport ctrl (output driveEnable, output dataValue, output functionSel, output sourceBits,
        input pinOut, input pinDrive);
    modport mux (input driveEnable, input dataValue, input functionSel, input sourceBits,
        output pinOut, output pinDrive);
endinterface

// *** hw/pin_mux_select.sv ***
// Combinational per-pin function selection.
// Assumes configuration arrives registered from the parent; source signals pass through unregistered.
`timescale 1ns/100ps
module pin_mux_select #(
    parameter int PINS = 4
) (
    pin_mux_if.mux bus
);
    // Source bit order: 0 serial, 1 full, 2 read done, 3 ready_n, 4 high, 5 low, 6 alert_n.
    for (genvar p = 0; p < PINS; p++) begin : g_pin
        pin_mux_pkg::pin_function_type fn;
        assign fn = pin_mux_pkg::pin_function_type'(bus.functionSel[p*4 +: 4]);
        always_comb begin
            bus.pinOut[p] = 1'b0;
            bus.pinDrive[p] = bus.driveEnable[p];
            case (fn)
                pin_mux_pkg::FN_SERIAL_OUT: bus.pinOut[p] = bus.sourceBits[0];
                pin_mux_pkg::FN_FIFO_FULL: bus.pinOut[p] = bus.sourceBits[1];
                pin_mux_pkg::FN_FIFO_READ_DONE: bus.pinOut[p] = bus.sourceBits[2];
                pin_mux_pkg::FN_FILTER_READY_N: bus.pinOut[p] = bus.sourceBits[3];
                pin_mux_pkg::FN_HIGH_DETECT: bus.pinOut[p] = bus.sourceBits[4];
                pin_mux_pkg::FN_LOW_DETECT: bus.pinOut[p] = bus.sourceBits[5];
                pin_mux_pkg::FN_ALERT_N: bus.pinOut[p] = bus.sourceBits[6];
                pin_mux_pkg::FN_REG_DATA: bus.pinOut[p] = bus.dataValue[p];
                // input functions never drive, guarding against a stale enable.
                pin_mux_pkg::FN_FILTER_SYNC_IN,
                pin_mux_pkg::FN_FIFO_TRIGGER_IN: bus.pinDrive[p] = 1'b0;
                default: bus.pinDrive[p] = 1'b0;
            endcase
        end
    end
endmodule

// *** hw/pin_input_sense.sv ***
// Turns sampled pin levels into the filter sync and FIFO trigger requests.
// Assumes pin inputs synchronous to clock.
`timescale 1ns/100ps
module pin_input_sense #(
    parameter int PINS = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [PINS*4-1:0] functionSel,
    input wire logic [PINS-1:0] driveEnable,
    input wire logic [PINS-1:0] pinLevel,
    output logic filterSyncN,
    output logic fifoTrigger
);
    logic syncAny;
    logic trigAny;

    always_comb begin
        syncAny = 1'b0;
        trigAny = 1'b0;
        for (int p = 0; p < PINS; p++) begin
            if (functionSel[p*4 +: 4] == pin_mux_pkg::FN_FILTER_SYNC_IN && !driveEnable[p]) begin
                syncAny = syncAny | ~pinLevel[p];
            end
            if (functionSel[p*4 +: 4] == pin_mux_pkg::FN_FIFO_TRIGGER_IN && !driveEnable[p]) begin
                trigAny = trigAny | pinLevel[p];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            filterSyncN <= 1'b1;
            fifoTrigger <= 1'b0;
        end else begin
            filterSyncN <= ~syncAny;
            fifoTrigger <= trigAny;
        end
    end
endmodule

// *** tb/host_pin_model.sv ***
// Host logic at the far side of the four multipurpose pins.
// Assumes the device enable is active low and that pins are sampled on clock.
`timescale 1ns/100ps
module host_pin_model (
    input wire logic clock,
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOe_n,
    input wire logic [3:0] hostValue,
    input wire logic [3:0] hostEnable,
    output logic [3:0] pinIn
);
    logic [3:0] lastReg;

    always_ff @(posedge clock) begin
        lastReg <= pinIn;
    end

    // The device wins a clash; an undriven pin toggles so a stale level never passes.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pinOe_n[i]) begin
                pinIn[i] = pinOut[i];
            end else if (hostEnable[i]) begin
                pinIn[i] = hostValue[i];
            end else begin
                pinIn[i] = ~lastReg[i];
            end
        end
    end
endmodule

// *** tb/multipurpose_pin_control_tb_top.sv ***
// Self-checking bench for the multipurpose pin block.
// Assumes the register header is on the include path and a host pin model.
`timescale 1ns/100ps
`include "pin_mux_regs.svh"
module multipurpose_pin_control_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regReadData;
    logic [3:0] pinIn;
    logic [3:0] pinOut;
    logic [3:0] pinOe_n;
    logic [3:0] hostValue = 4'hA;
    logic [3:0] hostEnable = 4'hE;
    logic [6:0] src = 7'h00;
    logic highDetectRouted;
    logic filterSyncN;
    logic fifoTrigger;
    int failCount = 0;
    int nTests = 0;

    always #12.5 clock = ~clock;

    pin_mux_top #(.PINS(4)) u_dut (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .serialDataOut(src[0]), .fifoFull(src[1]), .fifoReadDone(src[2]),
        .filterReadyN(src[3]), .highDetect(src[4]), .lowDetect(src[5]), .alertN(src[6]),
        .highDetectRouted(highDetectRouted), .filterSyncN(filterSyncN),
        .fifoTrigger(fifoTrigger));

    host_pin_model u_host (.clock(clock), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .hostValue(hostValue), .hostEnable(hostEnable), .pinIn(pinIn));

    // ----------------------------------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        d = regReadData;
    endtask

    // Pins follow a write two cycles later, so three edges always suffice.
    task automatic settle;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: register %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkPin(input logic [3:0] got, input logic [3:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: pins %b, expected %b", $time, got, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic testReset;
        logic [7:0] d;
        chkPin(pinOe_n, 4'hE);
        rd(`ADDR_DIR_DATA, d);
        chkReg(d, 8'hA1);
        rd(`ADDR_SEL_LOW, d);
        chkReg(d, 8'h00);
        rd(`ADDR_SEL_HIGH, d);
        chkReg(d, 8'h00);
        rd(8'h30, d);
        chkReg(d, 8'h00);
        $display("test reset done");
    endtask

    task automatic testSources;
        logic [3:0] code;
        logic [7:0] d;
        wr(`ADDR_DIR_DATA, 8'h0F);
        wr(`ADDR_ROUTE_CTRL, 8'h40);
        for (int c = 0; c < 7; c++) begin
            code = 4'(c);
            wr(`ADDR_SEL_LOW, {code, code});
            wr(`ADDR_SEL_HIGH, {code, code});
            src <= 7'(1 << c);
            settle();
            chkPin(pinOut, 4'hF);
            chkPin(pinOe_n, 4'h0);
            src <= ~7'(1 << c);
            settle();
            chkPin(pinOut, 4'h0);
            rd(`ADDR_SEL_HIGH, d);
            chkReg(d, {code, code});
        end
        $display("test sources done");
    endtask

    task automatic testRegData;
        logic [7:0] d;
        src <= 7'h01;
        wr(`ADDR_SEL_LOW, 8'h07);
        wr(`ADDR_SEL_HIGH, 8'h77);
        wr(`ADDR_DIR_DATA, 8'hAF);
        settle();
        chkPin(pinOut, 4'hA);
        src <= 7'h00;
        wr(`ADDR_DIR_DATA, 8'h5F);
        settle();
        chkPin(pinOut, 4'h5);
        rd(`ADDR_DIR_DATA, d);
        chkReg(d, 8'h5F);
        hostEnable <= 4'hF;
        hostValue <= 4'h3;
        wr(`ADDR_DIR_DATA, 8'h50);
        settle();
        chkPin(pinOe_n, 4'hF);
        rd(`ADDR_DIR_DATA, d);
        chkReg(d, 8'h30);
        $display("test register data done");
    endtask

    task automatic testInputs;
        wr(`ADDR_DIR_DATA, 8'h00);
        wr(`ADDR_SEL_LOW, 8'h80);
        wr(`ADDR_SEL_HIGH, 8'h09);
        hostValue <= 4'hD;
        settle();
        chkPin({2'b00, filterSyncN, fifoTrigger}, 4'h1);
        hostValue <= 4'h2;
        settle();
        chkPin({2'b00, filterSyncN, fifoTrigger}, 4'h2);
        hostEnable <= 4'h6;
        wr(`ADDR_DIR_DATA, 8'h0F);
        settle();
        chkPin(pinOe_n, 4'h6);
        $display("test inputs done");
    endtask

    task automatic testRoute;
        logic [7:0] d;
        src <= 7'h10;
        wr(`ADDR_ROUTE_CTRL, 8'h40);
        settle();
        chkPin({3'b000, highDetectRouted}, 4'h1);
        rd(`ADDR_ROUTE_CTRL, d);
        chkReg(d, 8'h40);
        wr(`ADDR_ROUTE_CTRL, 8'h00);
        settle();
        chkPin({3'b000, highDetectRouted}, 4'h0);
        $display("test route done");
    endtask

    task automatic stopTest;
        $display("comparisons %0d, mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        testReset();
        testSources();
        testRegData();
        testInputs();
        testRoute();
        stopTest();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        #100000;
        failCount++;
        stopTest();
    end
endmodule
